// ==== src/lcg_gate1_select.sv ====
// gate-1 input selection of a logic cell, ahb-lite register slave
// assumes data signals arrive synchronous to hclk from the cell
//
// What this block does
// - bit 5 set routes the true third data signal into gate 1.
// - bit 4 set routes the inverted third data signal into gate 1.
// - bit 3 set routes the true second data signal into gate 1.
// - bit 2 set routes the inverted second data signal into gate 1.
// - bit 1 set routes the true first data signal into gate 1.
// - bit 7 set routes the true fourth data signal into gate 1.
// - bit 6 set routes the inverted fourth data signal into gate 1.
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
module lcg_gate1_select (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] data_in,
  output logic [7:0] first_gate_signal
);
  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic is_ofs(input logic [31:0] a,
                                  input logic [11:0] o);
    is_ofs = (a[11:0] == o);
  endfunction

  // read word: selection register, gated-term view or zero
  function automatic logic [31:0] read_word(input logic [31:0] a,
                                            input logic [7:0] sel,
                                            input logic [7:0] view);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (is_ofs(a, lcg_pkg::GATE1_DATA_SELECT_OFS)) begin
      w = {24'h00_0000, sel};
    end else if (is_ofs(a, lcg_pkg::GATE1_OUTPUT_OFS)) begin
      w = {24'h00_0000, view};
    end
    read_word = w;
  endfunction

  logic [7:0] gate1_data_select_q;
  logic wr_pend_q;
  logic [31:0] addr_q;
  logic [7:0] terms;
  logic take;

  // ---------------------------------------------------------------
  // named selection fields
  // ---------------------------------------------------------------
  logic gate1_d1_inverted_select;
  logic gate1_d1_true_select;
  logic gate1_d2_inverted_select;
  logic gate1_d2_true_select;
  logic gate1_d3_inverted_select;
  logic gate1_d3_true_select;
  logic gate1_d4_inverted_select;
  logic gate1_d4_true_select;
  logic [7:0] sel_vec;

  // first data signal fields
  assign gate1_d1_inverted_select =
    gate1_data_select_q[lcg_pkg::D1_INV_POS];
  assign gate1_d1_true_select = gate1_data_select_q[lcg_pkg::D1_TRUE_POS];
  // second data signal fields
  assign gate1_d2_inverted_select =
    gate1_data_select_q[lcg_pkg::D2_INV_POS];
  assign gate1_d2_true_select = gate1_data_select_q[lcg_pkg::D2_TRUE_POS];
  // third data signal fields
  assign gate1_d3_inverted_select =
    gate1_data_select_q[lcg_pkg::D3_INV_POS];
  assign gate1_d3_true_select = gate1_data_select_q[lcg_pkg::D3_TRUE_POS];
  // fourth data signal fields
  assign gate1_d4_inverted_select =
    gate1_data_select_q[lcg_pkg::D4_INV_POS];
  assign gate1_d4_true_select = gate1_data_select_q[lcg_pkg::D4_TRUE_POS];

  // fields packed back in gating order, inverted term at even bits
  assign sel_vec = {gate1_d4_true_select, gate1_d4_inverted_select,
                    gate1_d3_true_select, gate1_d3_inverted_select,
                    gate1_d2_true_select, gate1_d2_inverted_select,
                    gate1_d1_true_select, gate1_d1_inverted_select};

  // ---------------------------------------------------------------
  // named gated terms
  // ---------------------------------------------------------------
  logic term_d1_inv;
  logic term_d1_true;
  logic term_d2_inv;
  logic term_d2_true;
  logic term_d3_inv;
  logic term_d3_true;
  logic term_d4_inv;
  logic term_d4_true;

  // first data signal terms
  assign term_d1_inv = terms[0];
  assign term_d1_true = terms[1];
  // second data signal terms
  assign term_d2_inv = terms[2];
  assign term_d2_true = terms[3];
  // third data signal terms
  assign term_d3_inv = terms[4];
  assign term_d3_true = terms[5];
  // fourth data signal terms
  assign term_d4_inv = terms[6];
  assign term_d4_true = terms[7];

  assign take = hsel & hready & htrans[1];
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0; // always okay

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= take & hwrite;
      if (take) begin
        addr_q <= haddr;
      end
    end
  end

  // selection register write in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate1_data_select_q <= lcg_pkg::GATE1_DATA_SELECT_RST;
    end else if (wr_pend_q &&
                 is_ofs(addr_q, lcg_pkg::GATE1_DATA_SELECT_OFS)) begin
      gate1_data_select_q <= hwdata[7:0];
    end
  end

  // read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= read_word(haddr, gate1_data_select_q, first_gate_signal);
    end
  end

  // ---------------------------------------------------------------
  // term selection
  // ---------------------------------------------------------------
  // per-bit gating of true and inverted data
  lcg_term_gate u_gate (
    .sel(sel_vec),
    .data_in(data_in),
    .terms(terms)
  );

  // selected terms registered toward the combiner
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_gate_signal <= 8'h00;
    end else begin
      first_gate_signal <= {term_d4_true, term_d4_inv,
                            term_d3_true, term_d3_inv,
                            term_d2_true, term_d2_inv,
                            term_d1_true, term_d1_inv};
    end
  end
endmodule

// ==== src/lcg_pkg.sv ====
// package for the gate-1 input selection block of a logic cell
// assumes an ahb-lite register bus with 32-bit data
package lcg_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] GATE1_DATA_SELECT_OFS = 12'h000;
  localparam logic [11:0] GATE1_OUTPUT_OFS = 12'h004;
  localparam logic [7:0] GATE1_DATA_SELECT_RST = 8'h00;
  // ---------------------------------------------------------------
  // field positions of the selection register
  // ---------------------------------------------------------------
  localparam int D1_INV_POS = 0;
  localparam int D1_TRUE_POS = 1;
  localparam int D2_INV_POS = 2;
  localparam int D2_TRUE_POS = 3;
  localparam int D3_INV_POS = 4;
  localparam int D3_TRUE_POS = 5;
  localparam int D4_INV_POS = 6;
  localparam int D4_TRUE_POS = 7;
  // ---------------------------------------------------------------
  // ahb encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ==== src/lcg_term_gate.sv ====
// term gating for the four data signals of gate 1
// assumes selection bits and data signals on the same clock
`timescale 1ns/1ns
module lcg_term_gate (
  input wire logic [7:0] sel,
  input wire logic [3:0] data_in,
  output logic [7:0] terms
);
  // each data signal yields an inverted term (even) and a true term (odd)
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_term
      assign terms[2*i] = sel[2*i] & ~data_in[i];
      assign terms[2*i+1] = sel[2*i+1] & data_in[i];
    end
  endgenerate
endmodule

// ==== verif/lcg_gate1_monitor.sv ====
// gate-1 term checker, bound into the selection block
// assumes data_in synchronous to hclk and terms registered one edge late
`timescale 1ns/1ns
module lcg_gate1_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] data_in,
  input wire logic [7:0] first_gate_signal
);
  wire [7:0] g = first_gate_signal;
  logic [3:0] d_q;
  always_ff @(posedge hclk) d_q <= data_in;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_d3_true: assert property (g[5]|->d_q[2]) else $error("d3t");
  chk_d3_inv: assert property (g[4]|->!d_q[2]) else $error("d3n");
  chk_d2_true: assert property (g[3]|->d_q[1]) else $error("d2t");
  chk_d2_inv: assert property (g[2]|->!d_q[1]) else $error("d2n");
  chk_d1_true: assert property (g[1]|->d_q[0]) else $error("d1t");
  chk_d4_true: assert property (g[7]|->d_q[3]) else $error("d4t");
  chk_d4_inv: assert property (g[6]|->!d_q[3]) else $error("d4n");
  chk_d1_inv: assert property (g[0]|->!d_q[0]) else $error("d1n");
endmodule
bind lcg_gate1_select lcg_gate1_monitor mon_u (.hclk, .hresetn, .data_in,
  .first_gate_signal);

// ==== verif/tb.sv ====
// gate-1 bench: ahb-lite register tasks and term checks
// assumes one slave with zero or more wait states, hready from hreadyout
`timescale 1ns/1ns
module tb;
  logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, hreadyout, hresp;
  logic [1:0] htrans = 0;
  logic [3:0] data_in = 0;
  logic [7:0] first_gate_signal;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, s, e;
  wire [31:0] g = {24'h0, first_gate_signal};
  int failures = 0, tests_run = 0;
  initial forever #5 hclk = ~hclk;
  lcg_gate1_select dut_u (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .data_in(data_in),
    .first_gate_signal(first_gate_signal)
  );
  task check(string n, logic [31:0] v, x);
    tests_run++;
    failures += int'(v !== x);
    if (v !== x) $display("CHECK FAILED %s exp %h got %h", n, x, v);
  endtask
  task bus(logic w, logic [31:0] a, d);
    {hwrite, htrans, haddr} <= {w, 2'h2, a};
    @(posedge hclk iff hreadyout);
    {htrans, hwdata} <= {2'h0, d};
    @(posedge hclk iff hreadyout);
  endtask
  task conclude(int extra);
    failures += extra;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial #20000 conclude(1);
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    check("okay", {hresp, hreadyout}, 1);
    bus(0, 0, 0);
    check("reset sel", hrdata, 0);
    bus(0, 8, 0);
    check("unmapped", hrdata, 0);
    for (int k = 0; k < 8; k++) begin
      s = 1 << k;
      bus(1, 0, s);
      for (int d = 0; d < 16; d++) begin
        @(posedge hclk) data_in <= d[3:0];
        repeat (2) @(negedge hclk);
        e = d[k/2] ? s : 0;
        if (k[0]) check("true", g, e);
        else check("inv", g, s ^ e);
      end
      bus(0, 0, 0);
      check("readback", hrdata, s);
      bus(0, 4, 0);
      check("view", hrdata, k[0] ? s : 0);
    end
    conclude(0);
  end
endmodule
